// File: hdl/cpc_cal_seq.sv
`timescale 1ns/10ps
`include "cpc_map.svh"
module cpc_cal_seq
   import cpc_pkg::*;
#(
   parameter int CAL_CYCLES = `CPC_CAL_CYCLES
)
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // active calibration bit
   input  wire logic cal_req,
   // calibration control
   output logic      cal_start,
   output logic      cal_busy
);

   localparam int CW = $clog2(CAL_CYCLES + 1);

   cpc_cal_state_t state_ff;
   cpc_cal_state_t nxt_state;
   logic [CW-1:0]  cnt_ff;
   logic [CW-1:0]  nxt_cnt;
   logic           req_d_ff;
   logic           start_ff;
   wire            req_rise = cal_req & ~req_d_ff;

   // a new run needs a 0 to 1 edge of the active bit
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      unique case (state_ff)
         CPC_CAL_IDLE:
            if (req_rise)
            begin
               nxt_state = CPC_CAL_RUN;
               nxt_cnt   = CW'(CAL_CYCLES - 1);
            end
         CPC_CAL_RUN:
            if (cnt_ff == '0)
               nxt_state = CPC_CAL_IDLE;
            else
               nxt_cnt = cnt_ff - 1'b1;
         default:
            nxt_state = CPC_CAL_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= CPC_CAL_IDLE;
         cnt_ff   <= '0;
         req_d_ff <= 1'b0;
         start_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         req_d_ff <= cal_req;
         start_ff <= (state_ff == CPC_CAL_IDLE) && req_rise;
      end
   end

   assign cal_start = start_ff;
   assign cal_busy  = (state_ff == CPC_CAL_RUN);

endmodule : cpc_cal_seq

// File: hdl/cpc_clock_path.sv
// Behaviour
// - pll power field 01 powers the pll down, 00 runs it normally
// - reset defaults: pll off, prescale code 010, prescaler in path, external clock
// - prescale code picks a divide ratio of two to six
// - bypass bit 0 feeds distribution from prescaler, 1 feeds source directly
// - source bit 0 routes external clock, 1 routes internal oscillator
// - polarity bit 0 positive slope, 1 negative slope
// - setting a cleared calibration bit then updating starts a calibration run unless one is busy
// - written values act only after 0x01 is written to the update register
// - defaults reload at power-up and on every reset
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "cpc_map.svh"
module cpc_clock_path
   import cpc_pkg::*;
#(
   parameter int CAL_CYCLES = `CPC_CAL_CYCLES
)
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // clock path settings
   output cpc_clk_cfg_t     clk_cfg,
   // oscillator calibration
   output logic             cal_start,
   output logic             cal_busy
);

   localparam int NREG = 4;

   // index and reset value of each buffered register
   localparam logic [9:0] REG_IDX [NREG] = '{
      `CPC_IDX_PLL_CTRL, `CPC_IDX_CAL_CTRL, `CPC_IDX_PRESCALE, `CPC_IDX_ROUTING};
   localparam logic [7:0] REG_RST [NREG] = '{
      `CPC_RST_PLL_CTRL, `CPC_RST_CAL_CTRL, `CPC_RST_PRESCALE, `CPC_RST_ROUTING};

   // prescale code to divide ratio; spare codes fall back to the largest ratio
   function automatic logic [2:0] ratio_of(input logic [2:0] code);
      logic [2:0] r;
      r = 3'h6;
      if (code <= 3'h4)
         r = code + 3'h2;
      return r;
   endfunction : ratio_of

   // word address match, low two bits must be zero
   function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
      return (a[1:0] == 2'h0) && (a[11:2] == idx);
   endfunction : hit

   // buffer and active copies, bus and output flops
   logic [7:0]   buf_q [NREG];
   logic [7:0]   act_q [NREG];
   logic [NREG-1:0] reg_sel;
   logic         upd_ff;
   logic         nxt_upd;
   logic [31:0]  prdata_ff;
   logic [31:0]  nxt_prdata;
   cpc_clk_cfg_t cfg_ff;
   cpc_clk_cfg_t nxt_cfg;
   logic         cal_start_w;
   logic         cal_busy_w;

   // bus phase and address decode
   wire setup_ph = psel & ~penable;
   wire acc_ph   = psel & penable;
   wire sel_upd  = hit(paddr, `CPC_IDX_UPDATE);
   wire sel_sts  = hit(paddr, `CPC_IDX_STATUS);
   wire mapped   = (|reg_sel) | sel_upd | sel_sts;
   wire bad_wr   = pwrite & sel_sts;     // status is read only
   wire wr_ok    = acc_ph & pwrite & mapped & ~bad_wr;
   wire upd_wr   = wr_ok & sel_upd & (pwdata[7:0] == `CPC_UPDATE_KEY);
   wire pending  = (buf_q[0] != act_q[0]) | (buf_q[1] != act_q[1]) |
                   (buf_q[2] != act_q[2]) | (buf_q[3] != act_q[3]);

   // buffered registers; the apply pulse is the self-clearing update flag
   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++)
      begin : g_reg
         assign reg_sel[gi] = hit(paddr, REG_IDX[gi]);
         cpc_shadow_reg #(
            .W   (8),
            .RST (REG_RST[gi])
         ) u_reg (
            .pclk    (pclk),
            .presetn (presetn),
            .wr_en   (wr_ok & reg_sel[gi]),
            .wr_data (pwdata[7:0]),
            .apply   (upd_ff),
            .buf_q   (buf_q[gi]),
            .act_q   (act_q[gi])
         );
      end
   endgenerate

   // zero wait states; error only on unmapped or read-only targets
   assign pready  = 1'b1;
   assign pslverr = acc_ph & (~mapped | bad_wr);

   // read data captured during setup so prdata comes from a flop
   always_comb
   begin
      nxt_prdata = prdata_ff;
      if (setup_ph & ~pwrite)
      begin
         nxt_prdata = 32'h0;
         for (int i = 0; i < NREG; i++)
            if (reg_sel[i])
               nxt_prdata[7:0] = buf_q[i];
         if (sel_upd)
            nxt_prdata[`CPC_UPDATE_BIT] = upd_ff;
         if (sel_sts)
            nxt_prdata[1:0] = {pending, cal_busy_w};
      end
   end

   // update flag lives exactly one cycle, so it clears itself
   assign nxt_upd = upd_wr;

   // decode of the active copies into the path settings
   always_comb
   begin
      nxt_cfg.pll_off =
         act_q[0][`CPC_PLL_PWR_MSB:`CPC_PLL_PWR_LSB] != `CPC_PLL_PWR_ON;
      nxt_cfg.pd_negative       = act_q[0][`CPC_PD_POL_BIT];
      nxt_cfg.prescale_ratio    =
         ratio_of(act_q[2][`CPC_PRESCALE_MSB:`CPC_PRESCALE_LSB]);
      nxt_cfg.prescaler_in_path = ~act_q[3][`CPC_BYPASS_BIT];
      nxt_cfg.src_internal_osc  = act_q[3][`CPC_SRC_BIT];
   end

   // output and bus flops; reset values match the register defaults
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upd_ff    <= 1'b0;
         prdata_ff <= 32'h0;
         cfg_ff    <= '{pll_off: 1'b1, pd_negative: 1'b0, prescale_ratio: 3'h4,
                        prescaler_in_path: 1'b1, src_internal_osc: 1'b0};
      end
      else
      begin
         upd_ff    <= nxt_upd;
         prdata_ff <= nxt_prdata;
         cfg_ff    <= nxt_cfg;
      end
   end

   // calibration runs on a rising edge of the active calibration bit
   cpc_cal_seq #(
      .CAL_CYCLES (CAL_CYCLES)
   ) u_cal (
      .pclk      (pclk),
      .presetn   (presetn),
      .cal_req   (act_q[1][`CPC_CAL_BIT]),
      .cal_start (cal_start_w),
      .cal_busy  (cal_busy_w)
   );

   assign prdata    = prdata_ff;
   assign clk_cfg   = cfg_ff;
   assign cal_start = cal_start_w;
   assign cal_busy  = cal_busy_w;

   // checks; the helper logic below exists only for them
   wire [31:0] act_flat = {act_q[0], act_q[1], act_q[2], act_q[3]};
   wire [31:0] buf_flat = {buf_q[0], buf_q[1], buf_q[2], buf_q[3]};

   property p_hold_until_update;
      @(posedge pclk) disable iff (!presetn)
      !upd_ff |=> $stable(act_flat);
   endproperty
   a_hold_until_update: assert property (p_hold_until_update)
      else $error("active settings changed without an update");

   property p_update_copies;
      @(posedge pclk) disable iff (!presetn)
      upd_ff |=> act_flat == $past(buf_flat);
   endproperty
   a_update_copies: assert property (p_update_copies)
      else $error("update did not copy all buffers");

   property p_update_self_clear;
      @(posedge pclk) disable iff (!presetn)
      upd_wr |=> upd_ff ##1 !upd_ff;
   endproperty
   a_update_self_clear: assert property (p_update_self_clear)
      else $error("update flag not a single cycle");

   property p_power_decode;
      @(posedge pclk) disable iff (!presetn)
      ##1 clk_cfg.pll_off ==
         ($past(act_q[0][`CPC_PLL_PWR_MSB:`CPC_PLL_PWR_LSB]) != `CPC_PLL_PWR_ON);
   endproperty
   a_power_decode: assert property (p_power_decode)
      else $error("pll power state wrong");

   property p_ratio_range;
      @(posedge pclk) disable iff (!presetn)
      upd_ff && buf_q[2][2:0] == 3'h2 |=> ##1 clk_cfg.prescale_ratio == 3'h4;
   endproperty
   a_ratio_range: assert property (p_ratio_range)
      else $error("prescale code 2 did not give divide by four");

   property p_routing;
      @(posedge pclk) disable iff (!presetn)
      ##1 clk_cfg.prescaler_in_path == !$past(act_q[3][`CPC_BYPASS_BIT]) &&
          clk_cfg.src_internal_osc == $past(act_q[3][`CPC_SRC_BIT]);
   endproperty
   a_routing: assert property (p_routing)
      else $error("routing does not follow active bits");

   property p_polarity;
      @(posedge pclk) disable iff (!presetn)
      upd_ff |=> ##1 clk_cfg.pd_negative == $past(buf_q[0][`CPC_PD_POL_BIT], 2);
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("polarity not applied two cycles after update");

   property p_cal_start;
      @(posedge pclk) disable iff (!presetn)
      upd_ff && buf_q[1][`CPC_CAL_BIT] && !act_q[1][`CPC_CAL_BIT] && !cal_busy
         |=> ##1 cal_start ##1 cal_busy;
   endproperty
   a_cal_start: assert property (p_cal_start)
      else $error("calibration did not start after update");

   property p_reset_defaults;
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> clk_cfg.pll_off && clk_cfg.prescale_ratio == 3'h4 &&
         clk_cfg.prescaler_in_path && !clk_cfg.src_internal_osc && !cal_busy;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("defaults not present after reset");

   // a refused access answers with an error and leaves every buffer alone
   property p_unmapped_err;
      @(posedge pclk) disable iff (!presetn)
      acc_ph && (!mapped || bad_wr) |-> pslverr && pready ##1 $stable(buf_flat);
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("refused access not answered with an error or changed a buffer");

   // every legal prescale code reaches the path as its own ratio
   genvar gc;
   generate
      for (gc = 0; gc < 5; gc++)
      begin : g_ratio_chk
         property p_ratio_code;
            @(posedge pclk) disable iff (!presetn)
            upd_ff && buf_q[2][2:0] == 3'(gc) |=> ##1 clk_cfg.prescale_ratio == 3'(gc + 2);
         endproperty
         a_ratio_code: assert property (p_ratio_code)
            else $error("prescale code gave the wrong divide ratio");
      end
   endgenerate

   // a taken write lands in the addressed buffer
   generate
      for (gc = 0; gc < NREG; gc++)
      begin : g_wr_chk
         property p_write_lands;
            @(posedge pclk) disable iff (!presetn)
            wr_ok && reg_sel[gc] |=> buf_q[gc] == $past(pwdata[7:0]);
         endproperty
         a_write_lands: assert property (p_write_lands)
            else $error("register write did not reach its buffer");
      end
   endgenerate

   // only the key value may raise the apply pulse
   property p_wrong_key;
      @(posedge pclk) disable iff (!presetn)
      acc_ph && pwrite && sel_upd && pwdata[7:0] != `CPC_UPDATE_KEY |=> !upd_ff;
   endproperty
   a_wrong_key: assert property (p_wrong_key)
      else $error("update applied without the key value");

   // after an apply no value is left pending
   property p_apply_clears_pending;
      @(posedge pclk) disable iff (!presetn)
      upd_ff |=> !pending;
   endproperty
   a_apply_clears_pending: assert property (p_apply_clears_pending)
      else $error("buffers still differ from active copies after update");

   // a rise that comes while a run is busy must not restart it
   property p_cal_no_restart;
      @(posedge pclk) disable iff (!presetn)
      cal_start |-> !$past(cal_busy);
   endproperty
   a_cal_no_restart: assert property (p_cal_no_restart)
      else $error("calibration restarted while busy");

   // length of the current busy stretch; too long for a repetition count
   logic [15:0] busy_len_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_len_ff <= 16'h0000;
      else if (cal_busy_w)
         busy_len_ff <= busy_len_ff + 16'h0001;
      else
         busy_len_ff <= 16'h0000;
   end

   property p_cal_length;
      @(posedge pclk) disable iff (!presetn)
      $fell(cal_busy) |-> busy_len_ff == 16'(CAL_CYCLES);
   endproperty
   a_cal_length: assert property (p_cal_length)
      else $error("calibration run length wrong");

   // registers are one byte wide, the rest of the read word stays zero
   property p_read_high_zero;
      @(posedge pclk) disable iff (!presetn)
      acc_ph && !pwrite |-> prdata[31:8] == 24'h000000;
   endproperty
   a_read_high_zero: assert property (p_read_high_zero)
      else $error("read data above the low byte not zero");

   c_update: cover property (@(posedge pclk) disable iff (!presetn) upd_wr);
   c_cal_run: cover property (@(posedge pclk) disable iff (!presetn)
      cal_start ##1 cal_busy);
   c_bypass: cover property (@(posedge pclk) disable iff (!presetn)
      !clk_cfg.prescaler_in_path);
   c_osc_src: cover property (@(posedge pclk) disable iff (!presetn)
      clk_cfg.src_internal_osc && !clk_cfg.pll_off);
   c_bad_key: cover property (@(posedge pclk) disable iff (!presetn)
      acc_ph && pwrite && sel_upd && !upd_wr);

endmodule : cpc_clock_path

// File: hdl/cpc_map.svh
`ifndef CPC_MAP_SVH
`define CPC_MAP_SVH

// register indices; byte address is four times the index
`define CPC_IDX_PLL_CTRL     10'h010
`define CPC_IDX_CAL_CTRL     10'h018
`define CPC_IDX_PRESCALE     10'h1e0
`define CPC_IDX_ROUTING      10'h1e1
`define CPC_IDX_UPDATE       10'h232
`define CPC_IDX_STATUS       10'h234

// field positions
`define CPC_PLL_PWR_LSB      0
`define CPC_PLL_PWR_MSB      1
`define CPC_PD_POL_BIT       7
`define CPC_CAL_BIT          0
`define CPC_PRESCALE_LSB     0
`define CPC_PRESCALE_MSB     2
`define CPC_BYPASS_BIT       0
`define CPC_SRC_BIT          1
`define CPC_UPDATE_BIT       0

// field encodings
`define CPC_PLL_PWR_ON       2'h0
`define CPC_PLL_PWR_OFF      2'h1
`define CPC_UPDATE_KEY       8'h01

// reset values
`define CPC_RST_PLL_CTRL     8'h01
`define CPC_RST_CAL_CTRL     8'h00
`define CPC_RST_PRESCALE     8'h02
`define CPC_RST_ROUTING      8'h00

// calibration run length in pclk cycles
`define CPC_CAL_CYCLES       64

`endif

// File: hdl/cpc_pkg.sv
package cpc_pkg;

   // decoded clock path settings driven to the analog side
   typedef struct packed {
      logic       pll_off;
      logic       pd_negative;
      logic [2:0] prescale_ratio;
      logic       prescaler_in_path;
      logic       src_internal_osc;
   } cpc_clk_cfg_t;

   // calibration sequencer states
   typedef enum logic [1:0] {
      CPC_CAL_IDLE = 2'b01,
      CPC_CAL_RUN  = 2'b10
   } cpc_cal_state_t;

endpackage : cpc_pkg

// File: hdl/cpc_shadow_reg.sv
`timescale 1ns/10ps
module cpc_shadow_reg
#(
   parameter int         W   = 8,
   parameter logic [W-1:0] RST = '0
)
(
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // software side
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wr_data,
   input  wire logic         apply,
   // buffered and active copies
   output logic      [W-1:0] buf_q,
   output logic      [W-1:0] act_q
);

   logic [W-1:0] buf_ff;
   logic [W-1:0] act_ff;

   // writes land in the buffer; only apply moves them to the active copy
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         buf_ff <= RST;
         act_ff <= RST;
      end
      else
      begin
         if (wr_en)
            buf_ff <= wr_data;
         if (apply)
            act_ff <= buf_ff;
      end
   end

   assign buf_q = buf_ff;
   assign act_q = act_ff;

endmodule : cpc_shadow_reg

// File: tb/tb_cpc_clock_path.sv
`timescale 1ns/10ps
`include "cpc_map.svh"
module tb_cpc_clock_path
   import cpc_pkg::*;
;
   // short calibration run keeps the bench quick
   localparam int CAL_N = 4;

   logic         pclk;
   logic         presetn;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [11:0]  paddr;
   logic [31:0]  pwdata;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   cpc_clk_cfg_t clk_cfg;
   cpc_clk_cfg_t dflt;
   cpc_clk_cfg_t exp_cfg;
   logic         cal_start;
   logic         cal_busy;
   int           failures;
   int           checked;
   int           starts;
   int           busy_cycles;
   logic [31:0]  rdat;
   logic         rerr;

   cpc_clock_path #(.CAL_CYCLES(CAL_N)) dut
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .clk_cfg   (clk_cfg),
      .cal_start (cal_start),
      .cal_busy  (cal_busy)
   );

   // free running bus clock
   always #4 pclk = ~pclk;

   // calibration pulses and busy length, counted independently of the bus
   always @(posedge pclk)
   begin
      if (cal_start === 1'b1) starts++;
      if (cal_busy === 1'b1) busy_cycles++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one apb transfer; entered just after a rising edge, leaves one idle cycle
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50) check(32'h0000dead, 32'h00000000);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic e);
      apb(1'b1, idx, d, rdat, rerr);
      check(rerr, e);
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [31:0] d, input logic e);
      apb(1'b0, idx, 8'h00, rdat, rerr);
      check(rdat, d);
      check(rerr, e);
   endtask : rd

   // update key write, then let the active copies reach the outputs
   task automatic upd();
      wr(`CPC_IDX_UPDATE, `CPC_UPDATE_KEY, 1'b0);
      repeat (3) @(posedge pclk);
   endtask : upd

   // sample settled outputs 1 ns after the edge, realign to the next edge
   task automatic cfg_chk(input cpc_clk_cfg_t e);
      #1;
      check(clk_cfg, e);
      @(posedge pclk);
   endtask : cfg_chk

   task automatic rst_seq();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : rst_seq

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // watchdog: whole run needs a few hundred cycles
   initial
   begin
      #200000;
      failures++;
      summarize();
   end

   initial
   begin
      pclk = 0;
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = '0;
      pwdata = '0;
      failures = 0;
      checked = 0;
      starts = 0;
      busy_cycles = 0;
      dflt = '{pll_off:1'b1, pd_negative:1'b0, prescale_ratio:3'd4,
               prescaler_in_path:1'b1, src_internal_osc:1'b0};
      rst_seq();
      cfg_chk(dflt);
      check(cal_busy, 1'b0);
      rd(`CPC_IDX_PLL_CTRL, {24'h0, `CPC_RST_PLL_CTRL}, 1'b0);
      rd(`CPC_IDX_CAL_CTRL, {24'h0, `CPC_RST_CAL_CTRL}, 1'b0);
      rd(`CPC_IDX_PRESCALE, {24'h0, `CPC_RST_PRESCALE}, 1'b0);
      rd(`CPC_IDX_ROUTING, {24'h0, `CPC_RST_ROUTING}, 1'b0);
      // pending values must not leak out, not even on a wrong key
      wr(`CPC_IDX_PLL_CTRL, 8'h80, 1'b0);
      wr(`CPC_IDX_ROUTING, 8'h01, 1'b0);
      rd(`CPC_IDX_ROUTING, 32'h00000001, 1'b0);
      rd(`CPC_IDX_STATUS, 32'h00000002, 1'b0);
      cfg_chk(dflt);
      wr(`CPC_IDX_UPDATE, 8'h02, 1'b0);
      repeat (3) @(posedge pclk);
      cfg_chk(dflt);
      rd(`CPC_IDX_STATUS, 32'h00000002, 1'b0);
      rd(`CPC_IDX_UPDATE, 32'h00000000, 1'b0);
      // every legal prescale code, both power codes and polarities, legal routings;
      // the oscillator source always keeps the prescaler in the path
      for (int i = 0; i < 5; i++)
      begin
         wr(`CPC_IDX_PLL_CTRL, {i[1], 6'h00, i[0]}, 1'b0);
         wr(`CPC_IDX_PRESCALE, {5'h00, 3'(i)}, 1'b0);
         wr(`CPC_IDX_ROUTING, {6'h00, i[1], i[0] & ~i[1]}, 1'b0);
         upd();
         exp_cfg = '{pll_off:i[0], pd_negative:i[1], prescale_ratio:3'(i + 2),
                     prescaler_in_path:!(i[0] & ~i[1]), src_internal_osc:i[1]};
         cfg_chk(exp_cfg);
         rd(`CPC_IDX_STATUS, 32'h00000000, 1'b0);
      end
      // calibration only starts on an applied rise of the bit
      starts = 0;
      busy_cycles = 0;
      wr(`CPC_IDX_CAL_CTRL, 8'h01, 1'b0);
      repeat (8) @(posedge pclk);
      check(starts, 0);
      upd();
      repeat (10) @(posedge pclk);
      check(starts, 1);
      check(busy_cycles, CAL_N);
      starts = 0;
      upd();
      repeat (10) @(posedge pclk);
      check(starts, 0);
      wr(`CPC_IDX_CAL_CTRL, 8'h00, 1'b0);
      upd();
      wr(`CPC_IDX_CAL_CTRL, 8'h01, 1'b0);
      upd();
      repeat (10) @(posedge pclk);
      check(starts, 1);
      check(busy_cycles, 2 * CAL_N);
      // unmapped place and read-only status refuse access
      wr(10'h011, 8'hff, 1'b1);
      rd(10'h011, 32'h00000000, 1'b1);
      wr(`CPC_IDX_STATUS, 8'h03, 1'b1);
      // spare power and prescale codes fall back to off and divide by six
      wr(`CPC_IDX_PLL_CTRL, 8'h02, 1'b0);
      wr(`CPC_IDX_PRESCALE, 8'h05, 1'b0);
      upd();
      exp_cfg = dflt;
      exp_cfg.prescale_ratio = 3'd6;
      cfg_chk(exp_cfg);
      // second reset in mid-run brings defaults back
      rst_seq();
      cfg_chk(dflt);
      rd(`CPC_IDX_PRESCALE, {24'h0, `CPC_RST_PRESCALE}, 1'b0);
      rd(`CPC_IDX_CAL_CTRL, {24'h0, `CPC_RST_CAL_CTRL}, 1'b0);
      rd(`CPC_IDX_PLL_CTRL, {24'h0, `CPC_RST_PLL_CTRL}, 1'b0);
      summarize();
   end
endmodule : tb_cpc_clock_path
